// *** bst_pkg.sv ***
/*
  boundary-scan tap package: state codes, instruction codes, scan cell
  positions and the functional pin bundle.
  assumes the tap logic runs on the test clock and the rest on sys_clk.
*/
package bst_pkg;

  typedef enum logic [15:0] {
    TAP_RESET    = 16'h0001,
    TAP_IDLE     = 16'h0002,
    TAP_SEL_DR   = 16'h0004,
    TAP_CAP_DR   = 16'h0008,
    TAP_SHIFT_DR = 16'h0010,
    TAP_EXIT1_DR = 16'h0020,
    TAP_PAUSE_DR = 16'h0040,
    TAP_EXIT2_DR = 16'h0080,
    TAP_UPD_DR   = 16'h0100,
    TAP_SEL_IR   = 16'h0200,
    TAP_CAP_IR   = 16'h0400,
    TAP_SHIFT_IR = 16'h0800,
    TAP_EXIT1_IR = 16'h1000,
    TAP_PAUSE_IR = 16'h2000,
    TAP_EXIT2_IR = 16'h4000,
    TAP_UPD_IR   = 16'h8000
  } bst_state_t;

  localparam int         IR_LEN      = 3;
  localparam logic [2:0] IR_EXTEST   = 3'h0;
  localparam logic [2:0] IR_IDCODE   = 3'h1;
  localparam logic [2:0] IR_SAMPLE   = 3'h2;
  localparam logic [2:0] IR_BYPASS   = 3'h7;
  localparam logic [2:0] IR_CAPTURE  = 3'h4;
  localparam logic [2:0] IR_RESET    = IR_IDCODE;

  localparam int BSR_FIRST   = 57;
  localparam int BSR_LEN     = 42;
  localparam int POS_INTERFACE_SELECT_ZERO   = 57;
  localparam int POS_OE      = 74;
  localparam int POS_RECEIVE_CLOCK_EDGE_SELECT    = 75;
  localparam int POS_REFCLK  = 92;
  localparam int POS_INTERFACE_SELECT_TWO   = 93;
  localparam int POS_ADDR_HI = 94;
  localparam int ADDR_W      = 5;
  // cells 64, 72, 79, 87 capture one; all other non-input cells capture zero
  localparam logic [41:0] BSR_HIGH_CELLS = 42'h000_4040_8080;
  localparam logic [41:0] BSR_RST        = 42'h000_0000_0000;

  typedef struct packed {
    logic              interface_select_zero;
    logic              output_enable;
    logic              receive_clock_edge_select;
    logic              reference_clock;
    logic              interface_select_two;
    logic [ADDR_W-1:0] address;
  } bst_pins_t;

endpackage

// *** bst_sync2.sv ***
/*
  two flip-flop level synchroniser, one per bit.
  assumes each bit is a quasi-static level in the source domain.
*/
`timescale 1ns/10ps
module bst_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // bst_sync2

// *** bst_tap_fsm.sv ***
/*
  sixteen-state tap controller stepped by tms on the rising test clock.
  assumes tms is driven synchronously to tck by the tester.
*/
`timescale 1ns/10ps
module bst_tap_fsm
  import bst_pkg::*;
(
  input  wire logic tck,
  input  wire logic rst_n,
  input  wire logic tms,
  output bst_state_t state_r
);
  bst_state_t state_nxt;

  function automatic bst_state_t tap_next(bst_state_t s, logic m);
    unique case (s)
      TAP_RESET:    tap_next = m ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     tap_next = m ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   tap_next = m ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   tap_next = m ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   tap_next = m ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   tap_next = m ? TAP_SEL_DR   : TAP_IDLE;
      default:      tap_next = TAP_RESET;
    endcase
  endfunction

  assign state_nxt = tap_next(state_r, tms);

  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= TAP_RESET;
    else
      state_r <= state_nxt;
  end
endmodule // bst_tap_fsm

// *** bst_tap_top.sv ***
/*
  boundary-scan test access port: tap controller, instruction register,
  identification, bypass and boundary scan tail (cells 57 to 98), and the
  hand-over of the latched boundary outputs into the sys_clk domain.
  assumes tck, tms, tdi come from an external tester; functional pins are
  asynchronous to tck; rst_n is the power-up reset for both domains.
*/
`timescale 1ns/10ps
module bst_tap_top
  import bst_pkg::*;
#(
  parameter logic [31:0] ID_CODE = 32'h0A5A_0001 // arbitrary value
) (
  input  wire logic           sys_clk,
  input  wire logic           rst_n,
  input  wire logic           tck,
  input  wire logic           tms,
  input  wire logic           tdi,
  output logic                tdo,
  output logic                tdo_oe,
  input  wire bst_pins_t      func_pins,
  output logic                extest_active,
  output logic [BSR_LEN-1:0]  bsr_parallel
);

  bst_state_t           state;
  bst_pins_t            pins_s;
  logic [IR_LEN-1:0]    ir_sh_r;
  logic [IR_LEN-1:0]    ir_cur_r;
  logic [BSR_LEN-1:0]   bsr_sh_r;
  logic [BSR_LEN-1:0]   bsr_upd_r;
  logic [31:0]          id_sh_r;
  logic                 byp_r;
  logic                 tdo_r;
  logic                 tdo_oe_r;
  logic                 upd_tog_r;
  logic                 ext_flag_r;
  logic [1:0]           sys_s;
  logic                 tog_seen_r;
  logic                 extest_r;
  logic [BSR_LEN-1:0]   bsr_par_r;

  // pin levels cross into the test clock domain
  bst_sync2 #(.WIDTH($bits(bst_pins_t))) u_pin_sync (
    .clk   (tck),
    .rst_n (rst_n),
    .d     (func_pins),
    .q     (pins_s)
  );

  bst_tap_fsm u_fsm (
    .tck     (tck),
    .rst_n   (rst_n),
    .tms     (tms),
    .state_r (state)
  );

  // state decode
  wire logic in_reset  = (state == TAP_RESET);
  wire logic in_cap_dr = (state == TAP_CAP_DR);
  wire logic in_sh_dr  = (state == TAP_SHIFT_DR);
  wire logic in_upd_dr = (state == TAP_UPD_DR);
  wire logic in_cap_ir = (state == TAP_CAP_IR);
  wire logic in_sh_ir  = (state == TAP_SHIFT_IR);
  wire logic in_upd_ir = (state == TAP_UPD_IR);

  function automatic logic sel_boundary(logic [IR_LEN-1:0] ir);
    sel_boundary = (ir == IR_EXTEST) || (ir == IR_SAMPLE);
  endfunction

  // data register selection by current instruction
  wire logic sel_bsr = sel_boundary(ir_cur_r);
  wire logic sel_id  = (ir_cur_r == IR_IDCODE);
  wire logic sel_byp = !sel_bsr && !sel_id;

  // place pin levels into the boundary tail; address msb first, lsb at 98
  function automatic logic [BSR_LEN-1:0] bsr_place(bst_pins_t p);
    logic [BSR_LEN-1:0] v;
    v = '0;
    v[POS_INTERFACE_SELECT_ZERO-BSR_FIRST]  = p.interface_select_zero;
    v[POS_OE-BSR_FIRST]     = p.output_enable;
    v[POS_RECEIVE_CLOCK_EDGE_SELECT-BSR_FIRST]   = p.receive_clock_edge_select;
    v[POS_REFCLK-BSR_FIRST] = p.reference_clock;
    v[POS_INTERFACE_SELECT_TWO-BSR_FIRST]  = p.interface_select_two;
    for (int i = 0; i < ADDR_W; i++)
      v[POS_ADDR_HI-BSR_FIRST+i] = p.address[ADDR_W-1-i];
    return v;
  endfunction

  wire logic [BSR_LEN-1:0] bsr_cap = bsr_place(pins_s) | BSR_HIGH_CELLS;

  // serial output of the selected data register
  wire logic dr_out = sel_bsr ? bsr_sh_r[0] : (sel_id ? id_sh_r[0] : byp_r);

  // boundary shift path; tdi enters cell 98, cell 57 feeds tdo
  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      bsr_sh_r <= BSR_RST;
    else if (in_cap_dr && sel_bsr)
      bsr_sh_r <= bsr_cap;
    else if (in_sh_dr && sel_bsr)
      bsr_sh_r <= {tdi, bsr_sh_r[BSR_LEN-1:1]};
  end

  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      id_sh_r <= 32'h0000_0000;
    else if (in_cap_dr && sel_id)
      id_sh_r <= ID_CODE;
    else if (in_sh_dr && sel_id)
      id_sh_r <= {tdi, id_sh_r[31:1]};
  end

  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      byp_r <= 1'b0;
    else if (in_cap_dr && sel_byp)
      byp_r <= 1'b0;
    else if (in_sh_dr && sel_byp)
      byp_r <= tdi;
  end

  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      ir_sh_r <= IR_CAPTURE;
    else if (in_cap_ir)
      ir_sh_r <= IR_CAPTURE;
    else if (in_sh_ir)
      ir_sh_r <= {tdi, ir_sh_r[IR_LEN-1:1]};
  end

  // current instruction changes only in reset or update-ir, on the falling edge
  always_ff @(negedge tck or negedge rst_n)
  begin
    if (!rst_n)
      ir_cur_r <= IR_RESET;
    else if (in_reset)
      ir_cur_r <= IR_RESET;
    else if (in_upd_ir)
      ir_cur_r <= ir_sh_r;
  end

  // latched parallel output, plus toggle to announce a new word
  always_ff @(negedge tck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bsr_upd_r <= BSR_RST;
      upd_tog_r <= 1'b0;
    end
    else if (in_upd_dr && sel_bsr)
    begin
      bsr_upd_r <= bsr_sh_r;
      upd_tog_r <= !upd_tog_r;
    end
  end

  // tdo changes on the falling edge, driven only while shifting
  always_ff @(negedge tck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end
    else
    begin
      tdo_r    <= in_sh_ir ? ir_sh_r[0] : dr_out;
      tdo_oe_r <= in_sh_dr || in_sh_ir;
    end
  end

  assign tdo    = tdo_r;
  assign tdo_oe = tdo_oe_r;

  // pins are overridden only with extest and outside reset
  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      ext_flag_r <= 1'b0;
    else
      ext_flag_r <= (ir_cur_r == IR_EXTEST) && !in_reset;
  end

  // sys_clk side: toggle handshake for the word, level sync for the flag
  bst_sync2 #(.WIDTH(2)) u_sys_sync (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     ({upd_tog_r, ext_flag_r}),
    .q     (sys_s)
  );

  wire logic new_word = sys_s[1] ^ tog_seen_r;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tog_seen_r <= 1'b0;
      extest_r   <= 1'b0;
      bsr_par_r  <= BSR_RST;
    end
    else
    begin
      tog_seen_r <= sys_s[1];
      extest_r   <= sys_s[0];
      if (new_word)
        bsr_par_r <= bsr_upd_r;
    end
  end

  assign extest_active = extest_r;
  assign bsr_parallel  = bsr_par_r;

  // checks in the test clock domain
  chk_five_ones_reset: assert property (@(posedge tck) disable iff (!rst_n)
    tms [*5] |=> (state == TAP_RESET))
    else $error("five tms ones did not reach reset");

  chk_reset_hold: assert property (@(posedge tck) disable iff (!rst_n)
    in_reset && tms |=> in_reset)
    else $error("left reset with tms high");

  chk_idle_hold: assert property (@(posedge tck) disable iff (!rst_n)
    (state == TAP_IDLE) && !tms |=> (state == TAP_IDLE) && $stable(ir_cur_r)
      && $stable(bsr_sh_r) && $stable(id_sh_r))
    else $error("idle did not hold state or registers");

  chk_idle_to_sel: assert property (@(posedge tck) disable iff (!rst_n)
    (state == TAP_IDLE) && tms |=> (state == TAP_SEL_DR))
    else $error("idle with tms high did not select dr");

  chk_sel_dr_branch: assert property (@(posedge tck) disable iff (!rst_n)
    (state == TAP_SEL_DR) |=> ($past(tms) ? (state == TAP_SEL_IR) : in_cap_dr)
      && $stable(bsr_sh_r))
    else $error("select-dr branch wrong");

  chk_capture_load: assert property (@(posedge tck) disable iff (!rst_n)
    in_cap_dr |=> (bsr_sh_r == ($past(sel_bsr) ? $past(bsr_cap) : $past(bsr_sh_r))))
    else $error("boundary capture wrong");

  chk_const_cells: assert property (@(posedge tck) disable iff (!rst_n)
    in_cap_dr && sel_bsr |=> bsr_sh_r[7] && bsr_sh_r[30] && !bsr_sh_r[1] && !bsr_sh_r[33])
    else $error("constant cells captured wrong level");

  chk_capture_exit: assert property (@(posedge tck) disable iff (!rst_n)
    in_cap_dr |=> ($past(tms) ? (state == TAP_EXIT1_DR) : in_sh_dr))
    else $error("capture-dr exit wrong");

  chk_shift_move: assert property (@(posedge tck) disable iff (!rst_n)
    in_sh_dr && sel_bsr |=> bsr_sh_r == {$past(tdi), $past(bsr_sh_r[BSR_LEN-1:1])})
    else $error("boundary shift wrong");

  chk_shift_stay: assert property (@(posedge tck) disable iff (!rst_n)
    in_sh_dr && !tms [*3] |=> in_sh_dr)
    else $error("shift-dr left with tms low");

  chk_exit1_branch: assert property (@(posedge tck) disable iff (!rst_n)
    (state == TAP_EXIT1_DR) |=> ($past(tms) ? in_upd_dr : (state == TAP_PAUSE_DR))
      && $stable(bsr_sh_r))
    else $error("exit1-dr branch wrong");

  chk_ir_stable_dr: assert property (@(posedge tck) disable iff (!rst_n)
    (state inside {TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR})
      |=> $stable(ir_cur_r))
    else $error("instruction changed in dr branch");

  chk_pause_exit2: assert property (@(posedge tck) disable iff (!rst_n)
    (state == TAP_PAUSE_DR) && tms ##1 tms |=> in_upd_dr)
    else $error("pause to exit2 to update failed");

  chk_update_only: assert property (@(posedge tck) disable iff (!rst_n)
    $changed(bsr_upd_r) |-> $past(in_upd_dr, 1) || in_upd_dr)
    else $error("parallel output changed outside update-dr");

  chk_cap_ir_value: assert property (@(posedge tck) disable iff (!rst_n)
    in_cap_ir |=> (ir_sh_r == IR_CAPTURE))
    else $error("capture-ir pattern wrong");

  chk_pause_hold: assert property (@(posedge tck) disable iff (!rst_n)
    (state == TAP_PAUSE_DR) && !tms |=> (state == TAP_PAUSE_DR)
      && $stable(bsr_sh_r) && $stable(ir_cur_r))
    else $error("pause-dr did not hold");

  chk_exit2_branch: assert property (@(posedge tck) disable iff (!rst_n)
    (state == TAP_EXIT2_DR) |=> ($past(tms) ? in_upd_dr : in_sh_dr)
      && $stable(bsr_sh_r))
    else $error("exit2-dr branch wrong");

  chk_tdo_enable: assert property (@(posedge tck) disable iff (!rst_n)
    tdo_oe == (in_sh_dr || in_sh_ir))
    else $error("tdo enable does not follow the shift states");

  chk_tdo_boundary: assert property (@(posedge tck) disable iff (!rst_n)
    in_sh_dr && sel_bsr |-> (tdo == bsr_sh_r[0]))
    else $error("tdo does not show the cell nearest it");

  chk_shift_unselected: assert property (@(posedge tck) disable iff (!rst_n)
    in_sh_dr && !sel_bsr |=> $stable(bsr_sh_r))
    else $error("boundary chain moved while not selected");

  chk_update_latch: assert property (@(posedge tck) disable iff (!rst_n)
    in_upd_dr && sel_bsr |-> (bsr_upd_r == bsr_sh_r))
    else $error("update-dr did not latch the shift path");

  chk_ir_only_update: assert property (@(posedge tck) disable iff (!rst_n)
    !in_upd_ir && !in_reset |-> $stable(ir_cur_r))
    else $error("instruction changed outside update-ir and reset");

  chk_reset_idcode: assert property (@(posedge tck) disable iff (!rst_n)
    in_reset |-> (ir_cur_r == IR_RESET))
    else $error("test-logic-reset without the identification instruction");

  chk_reset_no_extest: assert property (@(posedge tck) disable iff (!rst_n)
    in_reset |=> !ext_flag_r)
    else $error("external test flag set in test-logic-reset");

  // checks in the sys_clk domain
  chk_par_word: assert property (@(posedge sys_clk) disable iff (!rst_n)
    new_word |=> (bsr_par_r == $past(bsr_upd_r)))
    else $error("system copy of the boundary word wrong");

  chk_par_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !new_word |=> $stable(bsr_par_r))
    else $error("system copy changed without a new word");

  cov_shift_boundary: cover property (@(posedge tck) disable iff (!rst_n)
    in_sh_dr && sel_bsr ##1 in_sh_dr);

  cov_update_extest: cover property (@(posedge tck) disable iff (!rst_n)
    in_upd_dr && (ir_cur_r == IR_EXTEST));

  cov_update_ir: cover property (@(posedge tck) disable iff (!rst_n)
    in_upd_ir ##1 (state == TAP_IDLE));

  cov_pause_update: cover property (@(posedge tck) disable iff (!rst_n)
    (state == TAP_PAUSE_DR) ##1 (state == TAP_EXIT2_DR) ##1 in_upd_dr);

  cov_sys_word: cover property (@(posedge sys_clk) disable iff (!rst_n)
    new_word);

endmodule // bst_tap_top

// *** bst_tester.sv ***
/*
  tester model for the boundary-scan port: makes the test clock, mode select
  and serial data, and reads the serial output.
  assumes the bench steps it through its tasks; the test clock rests low between steps.
*/
`timescale 1ns/10ps
module bst_tester (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic tdo_line;

  // board pull-up holds the line high while the port does not drive it
  assign tdo_line = tdo_oe ? tdo : 1'b1;

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one test clock period; mode and data settle half a period before the rise
  task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
    tms = tms_v;
    tdi = tdi_v;
    #80;
    tck   = 1'b1;
    tdo_v = tdo_line;
    #80;
    tck = 1'b0;
    tdi = ~tdi_v;
  endtask

  // five high edges reach test-logic-reset from anywhere, extra ones must hold it
  task automatic force_reset(input int extra);
    logic d;
    for (int i = 0; i < 5 + extra; i++)
    begin
      step(1'b1, 1'b0, d);
    end
  endtask
endmodule // bst_tester

// *** boundary_scan_tap_controller_test.sv ***
/*
  self-checking bench for the boundary-scan port: identification read,
  instruction capture, sample and external-test scans, bypass, tms reset.
  assumes the tester model owns the test clock; sys_clk runs at 40 MHz.
*/
`timescale 1ns/10ps
module boundary_scan_tap_controller_test
  import bst_pkg::*;
;
  localparam logic [31:0] ID_VAL    = 32'h0C3C_0F01;      // arbitrary value
  localparam logic [41:0] RSV_MASK  = 42'h000_B8B9_7170;
  localparam logic [41:0] ONE_CELLS = 42'h000_4040_8080;  // cells 64, 72, 79, 87

  logic               sys_clk;
  logic               rst_n;
  logic               tck;
  logic               tms;
  logic               tdi;
  logic               tdo;
  logic               tdo_oe;
  logic               extest_active;
  bst_pins_t          func_pins;
  logic [BSR_LEN-1:0] bsr_parallel;
  int                 n_fail;
  int                 compares;

  bst_tap_top #(.ID_CODE(ID_VAL)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .func_pins(func_pins), .extest_active(extest_active),
    .bsr_parallel(bsr_parallel)
  );

  bst_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // cell 57+i sits at bit i; address cells run from the top bit down
  function automatic logic [41:0] exp_cap(input bst_pins_t p);
    logic [41:0] e;
    e     = ONE_CELLS;
    e[0]  = p.interface_select_zero;
    e[17] = p.output_enable;
    e[18] = p.receive_clock_edge_select;
    e[35] = p.reference_clock;
    e[36] = p.interface_select_two;
    for (int i = 0; i < 5; i++)
    begin
      e[37 + i] = p.address[4 - i];
    end
    return e;
  endfunction

  // tms levels taken lsb first
  task automatic walk(input logic [7:0] pat, input int n);
    logic d;
    for (int i = 0; i < n; i++)
    begin
      tester.step(pat[i], 1'b0, d);
    end
  endtask

  task automatic idle(input int n);
    walk(8'h00, n);
  endtask

  // shift n bits, pausing after bit split-1 when split lies inside the scan
  task automatic shift(input int n, input logic [63:0] din, input int split,
                       output logic [63:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      tester.step(i == n - 1 || i == split - 1, din[i], b);
      dout[i] = b;
      if (i == split - 1 && i != n - 1)
      begin
        walk(8'h04, 4);
      end
    end
    walk(8'h01, 2);
  endtask

  task automatic dr_scan(input int n, input logic [63:0] din, input int split,
                         output logic [63:0] dout);
    walk(8'h01, 3);
    #1;
    check({63'h0, tdo_oe}, 64'h1);
    shift(n, din, split, dout);
  endtask

  task automatic ir_load(input logic [2:0] code);
    logic [63:0] d;
    walk(8'h03, 4);
    shift(3, {61'h0, code}, 0, d);
    check({61'h0, d[2:0]}, 64'h4);
  endtask

  task automatic read_id();
    logic [63:0] d;
    dr_scan(32, {$urandom, $urandom}, $urandom_range(31, 1), d);
    check({32'h0, d[31:0]}, {32'h0, ID_VAL});
  endtask

  initial
  begin
    logic [63:0] din;
    logic [63:0] dout;
    logic [63:0] byp_in;
    logic [41:0] cap;
    bst_pins_t   pins;
    rst_n     = 1'b0;
    func_pins = '0;
    n_fail    = 0;
    compares  = 0;
    din       = {32'h0000_0000, $urandom(32'he841)};
    repeat (20) @(posedge sys_clk);
    check({62'h0, tdo_oe, extest_active}, 64'h0);
    check({22'h0, bsr_parallel}, 64'h0);
    @(negedge sys_clk);
    rst_n = 1'b1;
    idle(3);
    read_id();
    for (int k = 0; k < 4; k++)
    begin
      pins = (k == 0) ? '1 : (k == 1) ? '0 : bst_pins_t'($urandom);
      @(negedge sys_clk);
      func_pins = pins;
      ir_load((k == 3) ? IR_EXTEST : IR_SAMPLE);
      idle(3);
      cap = exp_cap(pins);
      walk(k[0] ? 8'h35 : 8'h0d, k[0] ? 7 : 5);
      idle(2);
      check({22'h0, bsr_parallel & ~RSV_MASK}, {22'h0, cap & ~RSV_MASK});
      din = {$urandom, $urandom};
      dr_scan(42, din, $urandom_range(41, 0), dout);
      check({22'h0, dout[41:0] & ~RSV_MASK}, {22'h0, cap & ~RSV_MASK});
      idle(2);
      check({22'h0, bsr_parallel}, {22'h0, din[41:0]});
      check({63'h0, extest_active}, {63'h0, k == 3});
    end
    ir_load(IR_BYPASS);
    byp_in = {$urandom, $urandom};
    dr_scan(8, byp_in, 0, dout);
    check({56'h0, dout[7:0]}, {56'h0, byp_in[6:0], 1'b0});
    idle(2);
    check({22'h0, bsr_parallel}, {22'h0, din[41:0]});
    ir_load(IR_EXTEST);
    idle(2);
    check({63'h0, extest_active}, 64'h1);
    walk(8'h01, 3);
    tester.force_reset(3);
    idle(3);
    check({63'h0, extest_active}, 64'h0);
    read_id();
    print_verdict();
  end

  initial
  begin
    #200000;
    n_fail++;
    print_verdict();
  end
endmodule // boundary_scan_tap_controller_test
